/* File: src/ao_chan_ctrl.v */
// channel control logic of a single channel analog output module
`timescale 1ns/100ps
`include "ao_chan_defs.vh"

// Functional notes
// - three consecutive failed exchanges, then 500 ms later the output is switched off
// - with error reporting set, module fault shows in module and global status
// - standard diagnosis bit plus extended station and module diagnosis byte
// - HART enable is a per-channel configuration bit
// - normal mode outputs the received value, simulation mode the simulated value
// - error behaviour triggers on a communication fault or invalid-data indication
// - current-value error mode keeps outputting the present (maybe simulated) value
// - substitute error mode outputs the configured substitute while the error lasts
// - last-valid error mode holds the latest (maybe simulated) value present without error
// - status option carries status bits in the low nibble of the data word
// - non-default scaling suppresses status bits even with status option on
// - 16-bit start maps to 0 percent, end to 100 percent; defaults 10000/50000
// - breakage detection reports lead breakage only, never short circuits
// - loop current below minimum threshold signals lead breakage
// - HART enable changeable only if station allows channel deactivation, else on
// - scan of HART channels on by default, can be switched off
// - one 16-bit word per channel, upper 12 bits process value, low 4 bits status if carried, else value
// - substitute and simulation values limited to -25 to 125 percent
module ao_chan_ctrl #(
  parameter        WDOG_CYCLES = `WDOG_CYCLES,
  parameter [11:0] ZERO_CODE   = 12'h028F,
  parameter [11:0] SPAN_CODE   = 12'h0A3E
) (
  // clock and reset
  input  wire        CORE_CLK_I,
  input  wire        SYS_RST_I,
  // wishbone slave
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  // exchange with the communication unit
  input  wire        XFER_OK_I,
  input  wire [15:0] XFER_WORD_I,
  input  wire        XFER_FAIL_I,
  // loop measurement and station options
  input  wire [15:0] LOOP_CURRENT_I,
  input  wire        HART_CHAN_DIS_ALLOWED_I,
  input  wire        SCAN_DIS_ALLOWED_I,
  // channel outputs
  output reg  [11:0] DAC_CODE_O,
  output reg         OUT_ENABLE_O,
  output reg         HART_EN_O,
  output reg         HART_SCAN_O,
  output reg         LEAD_BREAK_O,
  // status and diagnosis
  output reg         MODULE_STATUS_O,
  output reg         GLOBAL_STATUS_O,
  output reg         DIAG_STD_O,
  output reg  [7:0]  DIAG_EXT_O,
  output wire        IRQ_O
);

  // =====================================================================
  // helpers
  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
    end
  endfunction

  // saturate a signed percent (0.01 % units) into the -25..125 % window
  function [15:0] clamp_pct;
    input signed [31:0] v;
    begin
      if (v < $signed({16'hFFFF, `PCT_MIN}))
        clamp_pct = `PCT_MIN;
      else if (v > $signed({16'h0000, `PCT_MAX}))
        clamp_pct = `PCT_MAX;
      else
        clamp_pct = v[15:0];
    end
  endfunction

  // =====================================================================
  // registers
  reg  [7:0]  ctrl_q;
  reg  [15:0] start_q;
  reg  [15:0] end_q;
  reg  [15:0] subst_q;
  reg  [15:0] sim_q;
  reg  [15:0] min_cur_q;
  reg  [`IRQ_BITS-1:0] irq_st_q;
  reg  [`IRQ_BITS-1:0] irq_mask_q;
  reg  [15:0] fail_total_q;

  reg  [1:0]  fail_cnt_q;
  reg  [22:0] wd_cnt_q;
  reg         out_off_q;
  reg         invalid_q;
  reg  [15:0] rx_pct_q;
  reg  [15:0] last_pct_q;
  reg  [15:0] out_pct_q;
  reg         lead_prev_q;

  wire wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr    = wb_req & WB_WE_I;
  wire [15:0] wr16 = WB_DAT_I[15:0];

  // =====================================================================
  // scaling of the received word
  wire default_scale  = (start_q == `SCALE_START_RST) && (end_q == `SCALE_END_RST);
  wire status_carried = ctrl_q[`CTRL_STATUS_EN] & default_scale;
  wire [15:0] rx_val  = status_carried ? {XFER_WORD_I[15:4], 4'h0} : XFER_WORD_I;
  wire rx_invalid     = status_carried & XFER_WORD_I[0];

  wire signed [31:0] rx_diff  = $signed({16'h0000, rx_val}) - $signed({16'h0000, start_q});
  wire signed [31:0] span_raw = $signed({16'h0000, end_q}) - $signed({16'h0000, start_q});
  // zero span would divide by zero; treat as one count
  wire signed [31:0] span     = (span_raw == 32'sh0000_0000) ? 32'sh0000_0001 : span_raw;
  wire signed [31:0] rx_full  = (rx_diff * $signed(`PCT_FULL)) / span;

  // =====================================================================
  // value selection
  wire comm_fault = (fail_cnt_q != 2'h0);
  wire err_active = comm_fault | invalid_q;
  wire [15:0] base_pct = ctrl_q[`CTRL_SIM] ? sim_q : rx_pct_q;
  wire [1:0]  err_mode = ctrl_q[`CTRL_ERRM_HI:`CTRL_ERRM_LO];
  reg  [15:0] sel_pct;

  always @*
  begin
    sel_pct = base_pct;
    if (err_active)
    begin
      case (err_mode)
        `ERRM_CURRENT: sel_pct = base_pct;
        `ERRM_SUBST:   sel_pct = subst_q;
        `ERRM_LAST:    sel_pct = last_pct_q;
        default:       sel_pct = base_pct;
      endcase
    end
  end

  wire signed [31:0] dac_full = $signed({20'h0_0000, ZERO_CODE}) +
    ($signed({{16{out_pct_q[15]}}, out_pct_q}) * $signed({20'h0_0000, SPAN_CODE})) /
    $signed(`PCT_FULL);
  wire [11:0] dac_code = (dac_full < 32'sh0000_0000) ? 12'h000 :
                         (dac_full > 32'sh0000_0FFF) ? 12'hFFF : dac_full[11:0];

  // =====================================================================
  // lead breakage and module fault
  wire lead_break   = ctrl_q[`CTRL_BRK_EN] & (LOOP_CURRENT_I < min_cur_q);
  wire module_fault = out_off_q | lead_break;
  wire hart_eff     = HART_CHAN_DIS_ALLOWED_I ? ctrl_q[`CTRL_HART_EN] : 1'b1;
  wire scan_eff     = hart_eff & (SCAN_DIS_ALLOWED_I ? ctrl_q[`CTRL_SCAN_EN] : 1'b1);
  wire wd_trip      = (fail_cnt_q == `FAIL_LIMIT) & ~out_off_q &
                      (wd_cnt_q == WDOG_CYCLES[22:0] - 23'h00_0001);

  // =====================================================================
  // interrupt events
  wire [`IRQ_BITS-1:0] irq_ev;
  assign irq_ev[`IRQ_WDOG]       = wd_trip;
  assign irq_ev[`IRQ_LEAD_BREAK] = lead_break & ~lead_prev_q;
  assign irq_ev[`IRQ_COMM_FAIL]  = XFER_FAIL_I;
  assign irq_ev[`IRQ_INVALID]    = XFER_OK_I & rx_invalid;
  assign IRQ_O = |(irq_st_q & irq_mask_q);

  // =====================================================================
  // register file
  always @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ctrl_q     <= `CTRL_RESET;
      start_q    <= `SCALE_START_RST;
      end_q      <= `SCALE_END_RST;
      subst_q    <= 16'h0000;
      sim_q      <= 16'h0000;
      min_cur_q  <= `MIN_CURRENT_RST;
      irq_mask_q <= {`IRQ_BITS{1'b0}};
      irq_st_q   <= {`IRQ_BITS{1'b0}};
    end
    else
    begin
      if (wb_wr)
      begin
        case (WB_ADR_I)
          `OFS_CTRL:        if (WB_SEL_I[0]) ctrl_q <= WB_DAT_I[7:0];
          `OFS_SCALE_START: start_q <= merge16(start_q, wr16, WB_SEL_I[1:0]);
          `OFS_SCALE_END:   end_q <= merge16(end_q, wr16, WB_SEL_I[1:0]);
          `OFS_SUBST_PCT:   subst_q <= clamp_pct($signed({{16{wr16[15]}}, wr16}));
          `OFS_SIM_PCT:     sim_q <= clamp_pct($signed({{16{wr16[15]}}, wr16}));
          `OFS_MIN_CURRENT: min_cur_q <= merge16(min_cur_q, wr16, WB_SEL_I[1:0]);
          `OFS_IRQ_MASK:    if (WB_SEL_I[0]) irq_mask_q <= WB_DAT_I[`IRQ_BITS-1:0];
          default:          ;
        endcase
      end
      // new events win over a write-one clear in the same cycle
      if (wb_wr && WB_ADR_I == `OFS_IRQ_STATUS && WB_SEL_I[0])
        irq_st_q <= (irq_st_q & ~WB_DAT_I[`IRQ_BITS-1:0]) | irq_ev;
      else
        irq_st_q <= irq_st_q | irq_ev;
    end
  end

  // =====================================================================
  // wishbone answer: one wait-free registered ack per request
  always @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE_I)
      begin
        case (WB_ADR_I)
          `OFS_CTRL:        WB_DAT_O <= {24'h00_0000, ctrl_q};
          `OFS_SCALE_START: WB_DAT_O <= {16'h0000, start_q};
          `OFS_SCALE_END:   WB_DAT_O <= {16'h0000, end_q};
          `OFS_SUBST_PCT:   WB_DAT_O <= {16'h0000, subst_q};
          `OFS_SIM_PCT:     WB_DAT_O <= {16'h0000, sim_q};
          `OFS_MIN_CURRENT: WB_DAT_O <= {16'h0000, min_cur_q};
          `OFS_STATUS:      WB_DAT_O <= {22'h00_0000, scan_eff, hart_eff, status_carried,
                                         module_fault, fail_cnt_q, lead_break,
                                         err_active, invalid_q, out_off_q};
          `OFS_IRQ_STATUS:  WB_DAT_O <= {28'h000_0000, irq_st_q};
          `OFS_IRQ_MASK:    WB_DAT_O <= {28'h000_0000, irq_mask_q};
          `OFS_OUT_PCT:     WB_DAT_O <= {16'h0000, out_pct_q};
          `OFS_FAIL_TOTAL:  WB_DAT_O <= {16'h0000, fail_total_q};
          default:          WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // =====================================================================
  // exchange tracking and watchdog
  always @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      fail_cnt_q   <= 2'h0;
      wd_cnt_q     <= 23'h00_0000;
      out_off_q    <= 1'b0;
      invalid_q    <= 1'b0;
      rx_pct_q     <= 16'h0000;
      fail_total_q <= 16'h0000;
    end
    else
    begin
      // a failure reported together with a success counts as a failure
      if (XFER_FAIL_I)
      begin
        if (fail_cnt_q != `FAIL_LIMIT)
          fail_cnt_q <= fail_cnt_q + 2'h1;
        if (fail_total_q != 16'hFFFF)
          fail_total_q <= fail_total_q + 16'h0001;
      end
      else if (XFER_OK_I)
      begin
        fail_cnt_q <= 2'h0;
        wd_cnt_q   <= 23'h00_0000;
        out_off_q  <= 1'b0;
        invalid_q  <= rx_invalid;
        rx_pct_q   <= clamp_pct(rx_full);
      end
      if (!XFER_OK_I || XFER_FAIL_I)
      begin
        if (fail_cnt_q == `FAIL_LIMIT && !out_off_q)
        begin
          if (wd_trip)
            out_off_q <= 1'b1;
          else
            wd_cnt_q <= wd_cnt_q + 23'h00_0001;
        end
      end
    end
  end

  // =====================================================================
  // output value pipeline and pin drivers
  always @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      last_pct_q      <= 16'h0000;
      out_pct_q       <= 16'h0000;
      lead_prev_q     <= 1'b0;
      DAC_CODE_O      <= 12'h000;
      OUT_ENABLE_O    <= 1'b0;
      HART_EN_O       <= 1'b1;
      HART_SCAN_O     <= 1'b1;
      LEAD_BREAK_O    <= 1'b0;
      MODULE_STATUS_O <= 1'b0;
      GLOBAL_STATUS_O <= 1'b0;
      DIAG_STD_O      <= 1'b0;
      DIAG_EXT_O      <= 8'h00;
    end
    else
    begin
      if (!err_active)
        last_pct_q <= base_pct;
      out_pct_q    <= sel_pct;
      lead_prev_q  <= lead_break;
      // switched-off channel drives zero current
      DAC_CODE_O   <= out_off_q ? 12'h000 : dac_code;
      OUT_ENABLE_O <= ~out_off_q;
      HART_EN_O    <= hart_eff;
      HART_SCAN_O  <= scan_eff;
      LEAD_BREAK_O <= lead_break;
      MODULE_STATUS_O <= ctrl_q[`CTRL_ERR_REPORT] & module_fault;
      GLOBAL_STATUS_O <= ctrl_q[`CTRL_ERR_REPORT] & module_fault;
      DIAG_STD_O   <= module_fault;
      DIAG_EXT_O   <= {fail_cnt_q, status_carried, comm_fault,
                       invalid_q, lead_break, out_off_q, module_fault};
    end
  end

endmodule

/* File: src/ao_chan_defs.vh */
// constants for the analog output channel control block
`ifndef AO_CHAN_DEFS_VH
`define AO_CHAN_DEFS_VH

// =====================================================================
// register offsets (byte addresses)
`define OFS_CTRL        8'h00
`define OFS_SCALE_START 8'h04
`define OFS_SCALE_END   8'h08
`define OFS_SUBST_PCT   8'h0C
`define OFS_SIM_PCT     8'h10
`define OFS_MIN_CURRENT 8'h14
`define OFS_STATUS      8'h18
`define OFS_IRQ_STATUS  8'h1C
`define OFS_IRQ_MASK    8'h20
`define OFS_OUT_PCT     8'h24
`define OFS_FAIL_TOTAL  8'h28

// =====================================================================
// control fields
`define CTRL_SIM        0
`define CTRL_ERRM_LO    1
`define CTRL_ERRM_HI    2
`define CTRL_STATUS_EN  3
`define CTRL_BRK_EN     4
`define CTRL_HART_EN    5
`define CTRL_SCAN_EN    6
`define CTRL_ERR_REPORT 7
`define CTRL_RESET      8'h60

// error modes
`define ERRM_CURRENT    2'h0
`define ERRM_SUBST      2'h1
`define ERRM_LAST       2'h2

// =====================================================================
// interrupt bits
`define IRQ_WDOG        0
`define IRQ_LEAD_BREAK  1
`define IRQ_COMM_FAIL   2
`define IRQ_INVALID     3
`define IRQ_BITS        4

// =====================================================================
// reset values and limits
`define SCALE_START_RST 16'h2710
`define SCALE_END_RST   16'hC350
`define PCT_MIN         16'hF63C
`define PCT_MAX         16'h30D4
`define PCT_FULL        32'h0000_2710
`define MIN_CURRENT_RST 16'h0000
`define FAIL_LIMIT      2'h3

// =====================================================================
// timing
`define CLK_KHZ         10000
`define WDOG_TIME_MS    500
`define WDOG_CYCLES     (`WDOG_TIME_MS * `CLK_KHZ)

`endif

/* File: tb/ao_chan_chk_sva.sv */
// port assertions for the channel control block
`timescale 1ns/100ps
module ao_chan_chk #(
  parameter WDOG_CYCLES = 20
) (
  // clock and reset
  input wire        CORE_CLK_I,
  input wire        SYS_RST_I,
  // exchange and options
  input wire        XFER_OK_I,
  input wire        XFER_FAIL_I,
  input wire        HART_CHAN_DIS_ALLOWED_I,
  input wire        SCAN_DIS_ALLOWED_I,
  // outputs
  input wire [11:0] DAC_CODE_O,
  input wire        OUT_ENABLE_O,
  input wire        HART_EN_O,
  input wire        HART_SCAN_O,
  input wire        LEAD_BREAK_O,
  input wire        MODULE_STATUS_O,
  input wire        GLOBAL_STATUS_O,
  input wire        DIAG_STD_O,
  input wire [7:0]  DIAG_EXT_O
);
  reg  [31:0] wait_q;
  wire        armed = DIAG_EXT_O[7:6] == 2'h3 && !DIAG_EXT_O[1];
  // cycles spent armed with the output still on
  always @(posedge CORE_CLK_I)
    if (SYS_RST_I || !armed)
      wait_q <= 32'h0000_0000;
    else
      wait_q <= wait_q + 32'h0000_0001;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence three_fails;
    XFER_FAIL_I ##1 XFER_FAIL_I ##1 XFER_FAIL_I ##1 !XFER_OK_I;
  endsequence
  sequence ok_quiet;
    XFER_OK_I && !XFER_FAIL_I ##1 !XFER_FAIL_I [*3];
  endsequence
  a_fail_saturate: assert property (three_fails |=> DIAG_EXT_O[7:6] == 2'h3)
    else $error("fail count not three");
  a_wdog_delay: assert property ($rose(DIAG_EXT_O[1]) |->
    wait_q + 3 >= WDOG_CYCLES && wait_q <= WDOG_CYCLES + 3) else $error("watchdog delay");
  a_off_output: assert property (DIAG_EXT_O[1] |->
    !OUT_ENABLE_O && DAC_CODE_O == 12'h000) else $error("output not off");
  a_ok_clears: assert property (ok_quiet |-> DIAG_EXT_O[7:6] == 2'h0)
    else $error("fail count kept");
  a_status_pair: assert property (MODULE_STATUS_O == GLOBAL_STATUS_O &&
    (!MODULE_STATUS_O || DIAG_STD_O)) else $error("status pair differs");
  a_diag_std: assert property (DIAG_STD_O == (DIAG_EXT_O[1] | DIAG_EXT_O[2]))
    else $error("diag mismatch");
  a_hart_forced: assert property (!HART_CHAN_DIS_ALLOWED_I |=> HART_EN_O)
    else $error("hart not forced on");
  a_scan_default: assert property (!HART_CHAN_DIS_ALLOWED_I && !SCAN_DIS_ALLOWED_I
    |=> HART_SCAN_O) else $error("scan not on");
  a_break_diag: assert property (LEAD_BREAK_O == DIAG_EXT_O[2])
    else $error("break diag differs");
endmodule
bind ao_chan_ctrl ao_chan_chk #(.WDOG_CYCLES(WDOG_CYCLES)) ao_chan_chk_i (
  .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .XFER_OK_I(XFER_OK_I),
  .XFER_FAIL_I(XFER_FAIL_I), .HART_CHAN_DIS_ALLOWED_I(HART_CHAN_DIS_ALLOWED_I),
  .SCAN_DIS_ALLOWED_I(SCAN_DIS_ALLOWED_I), .DAC_CODE_O(DAC_CODE_O),
  .OUT_ENABLE_O(OUT_ENABLE_O), .HART_EN_O(HART_EN_O), .HART_SCAN_O(HART_SCAN_O),
  .LEAD_BREAK_O(LEAD_BREAK_O), .MODULE_STATUS_O(MODULE_STATUS_O),
  .GLOBAL_STATUS_O(GLOBAL_STATUS_O), .DIAG_STD_O(DIAG_STD_O), .DIAG_EXT_O(DIAG_EXT_O));

/* File: tb/comm_unit_model.sv */
// model of the communication unit sending exchange pulses
`timescale 1ns/100ps
module comm_unit_model (
  // clock
  input  wire        clk_i,
  // exchange
  output reg         xfer_ok_o,
  output reg         xfer_fail_o,
  output reg  [15:0] xfer_word_o
);
  initial
  begin
    xfer_ok_o   = 1'b0;
    xfer_fail_o = 1'b0;
    xfer_word_o = 16'h0000;
  end
  // c pulses back to back; word scrambled outside the pulse
  task send(input f, input [15:0] w, input integer c);
    begin
      @(posedge clk_i);
      xfer_ok_o   <= !f;
      xfer_fail_o <= f;
      xfer_word_o <= w;
      repeat (c) @(posedge clk_i);
      xfer_ok_o   <= 1'b0;
      xfer_fail_o <= 1'b0;
      xfer_word_o <= ~w;
    end
  endtask
endmodule

/* File: tb/analog_output_channel_control_bench.sv */
// self-checking bench for the channel control block
`timescale 1ns/100ps
`include "ao_chan_defs.vh"
module analog_output_channel_control_bench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         cyc = 1'b0;
  reg         we  = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wd  = 32'h0000_0000;
  reg  [15:0] cur = 16'h0000;
  reg         hdis = 1'b0;
  reg         sdis = 1'b0;
  wire [31:0] rdat;
  wire [15:0] word;
  wire [11:0] dac;
  wire [7:0]  dext;
  wire        ack, ok, fail, oe, hart, scan, brk, irq, mst, gst, dstd;
  integer     failures = 0;
  integer     compares = 0;
  integer     n;
  ao_chan_ctrl #(.WDOG_CYCLES(20)) ao_chan_ctrl_i (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack), .XFER_OK_I(ok), .XFER_WORD_I(word),
    .XFER_FAIL_I(fail), .LOOP_CURRENT_I(cur), .HART_CHAN_DIS_ALLOWED_I(hdis),
    .SCAN_DIS_ALLOWED_I(sdis), .DAC_CODE_O(dac), .OUT_ENABLE_O(oe), .HART_EN_O(hart),
    .HART_SCAN_O(scan), .LEAD_BREAK_O(brk), .MODULE_STATUS_O(mst), .GLOBAL_STATUS_O(gst),
    .DIAG_STD_O(dstd), .DIAG_EXT_O(dext), .IRQ_O(irq));
  comm_unit_model comm_unit_model_i (.clk_i(clk), .xfer_ok_o(ok), .xfer_fail_o(fail),
    .xfer_word_o(word));
  always #50 clk = ~clk;
  task final_report;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    integer k;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      k = 0;
      do
        begin
          @(posedge clk);
          k = k + 1;
        end
      while (ack !== 1'b1 && k < 16);
      q = rdat;
      cyc <= 1'b0;
      if (k >= 16)
      begin
        failures = failures + 1;
        final_report;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input [7:0] a, input [15:0] e);
    reg [31:0] q;
    begin
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q[15:0], e);
    end
  endtask
  task xf(input f, input [15:0] w, input integer c);
    comm_unit_model_i.send(f, w, c);
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task done(input [63:0] s);
    $display("test %0s done", s);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_CTRL, 16'h0060);
    rd(`OFS_SCALE_START, 16'h2710);
    rd(`OFS_SCALE_END, 16'hC350);
    rd(8'h30, 16'h0000);
    chk({hart, scan}, 2'h3);
    done("reset");
    xf(1'b0, 16'h7530, 1);
    rd(`OFS_OUT_PCT, 16'h1388);
    chk(dac, 16'h07AE);
    wr(`OFS_SIM_PCT, 32'h0000_07D0);
    wr(`OFS_CTRL, 32'h0000_0061);
    rd(`OFS_OUT_PCT, 16'h07D0);
    wr(`OFS_SIM_PCT, 32'h0000_32C8);
    rd(`OFS_OUT_PCT, 16'h30D4);
    wr(`OFS_SIM_PCT, 32'hFFFF_F448);
    rd(`OFS_OUT_PCT, 16'hF63C);
    done("mode");
    // modes current, substitute, last against one invalid word
    wr(`OFS_SUBST_PCT, 32'h0000_03E8);
    for (n = 0; n < 3; n = n + 1)
    begin
      wr(`OFS_CTRL, 32'h0000_0068 | (n << 1));
      xf(1'b0, 16'h7530, 1);
      xf(1'b0, 16'h9C41, 1);
      rd(`OFS_OUT_PCT, !n ? 16'h1D4C : n[0] ? 16'h03E8 : 16'h1388);
    end
    wr(`OFS_SCALE_START, 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_006A);
    xf(1'b0, 16'h9C41, 1);
    rd(`OFS_OUT_PCT, 16'h1F40);
    wr(`OFS_SCALE_START, 32'h0000_2710);
    xf(1'b1, 16'h0000, 1);
    rd(`OFS_OUT_PCT, 16'h03E8);
    xf(1'b0, 16'h7530, 1);
    rd(`OFS_OUT_PCT, 16'h1388);
    chk(dext[7:6], 2'h0);
    done("error");
    wr(`OFS_CTRL, 32'h0000_00E0);
    xf(1'b1, 16'h0000, 2);
    xf(1'b0, 16'h7530, 1);
    xf(1'b1, 16'h0000, 2);
    tick(30);
    chk(oe, 1'b1);
    xf(1'b0, 16'h7530, 1);
    xf(1'b1, 16'h0000, 3);
    n = 0;
    while (oe === 1'b1 && n < 60)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(n >= 16 && n <= 28, 1'b1);
    chk({dac, mst, gst}, 14'h0003);
    rd(`OFS_STATUS, 16'h0375);
    rd(`OFS_FAIL_TOTAL, 16'h0008);
    chk(irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    chk(irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h0000_0001);
    tick(1);
    chk(irq, 1'b0);
    rd(`OFS_IRQ_STATUS, 16'h000C);
    xf(1'b0, 16'h7530, 1);
    tick(3);
    chk(oe, 1'b1);
    done("wdog");
    hdis <= 1'b1;
    sdis <= 1'b1;
    wr(`OFS_CTRL, 32'h0000_0040);
    tick(2);
    chk(hart, 1'b0);
    wr(`OFS_CTRL, 32'h0000_0020);
    tick(2);
    chk({hart, scan}, 2'h2);
    hdis <= 1'b0;
    sdis <= 1'b0;
    tick(2);
    chk({hart, scan}, 2'h3);
    done("hart");
    wr(`OFS_MIN_CURRENT, 32'h0000_0064);
    wr(`OFS_CTRL, 32'h0000_0070);
    cur <= 16'h0032;
    tick(3);
    chk({brk, mst, gst, dstd}, 4'h9);
    cur <= 16'h00C8;
    tick(3);
    chk(brk, 1'b0);
    cur <= 16'h0032;
    wr(`OFS_CTRL, 32'h0000_0060);
    tick(2);
    chk(brk, 1'b0);
    rd(`OFS_IRQ_STATUS, 16'h000E);
    done("break");
    final_report;
  end
endmodule
